// *** rtl/cscr_pkg.sv ***
/*
  Package for the charger status and configuration register bank: register
  offsets, field layouts, reset values, serial-link constants and carrier types.
  Assumes it is compiled before every other design file of the block.
*/
`default_nettype none
package cscr_pkg;

  // Serial slave address and register offsets.
  localparam logic [6:0] SLAVE_ADDR     = 7'h48;
  localparam logic [7:0] OFS_STATUS     = 8'h00;
  localparam logic [7:0] OFS_CFG_COOL   = 8'h02;
  localparam logic [7:0] OFS_CFG_WARM   = 8'h03;
  localparam logic [7:0] OFS_CFG_ENABLE = 8'h11;

  // Reset values; the configuration bytes would normally come from non-volatile storage.
  localparam logic [7:0] STATUS_RST     = 8'h00;
  localparam logic [7:0] CFG_COOL_RST   = 8'h00;
  localparam logic [7:0] CFG_WARM_RST   = 8'h00;
  localparam logic [7:0] CFG_ENABLE_RST = 8'h00;
  localparam logic [7:0] READ_ZERO      = 8'h00;

  // Position of the access-enable bit in the configuration-enable register.
  localparam int unsigned CFG_EN_BIT = 0;

  // Serial byte framing.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE   = 4'h1;
  localparam logic [7:0] PTR_STEP      = 8'h01;

  // Termination-voltage code that the hardware must not apply.
  localparam logic [2:0] VTERM_INVALID = 3'h7;

  // Sticky status byte, most significant bit first.
  typedef struct packed {
    logic battery_overvoltage_flag;
    logic full_charge_timeout_flag;
    logic too_cold_flag;
    logic too_hot_flag;
    logic thermal_shutdown_flag;
    logic topoff_timeout_flag;
    logic input_undervoltage_flag;
    logic thermistor_open_flag;
  } cscr_status_type;

  localparam cscr_status_type FAULT_MASK = 8'hF0;

  // Configuration byte at the first configuration offset.
  typedef struct packed {
    logic [1:0] precharge_current_code;
    logic [2:0] vterm_cool_code;
    logic [2:0] vterm_mild_code;
  } cscr_cfg_cool_type;

  // Configuration byte at the second configuration offset.
  typedef struct packed {
    logic [1:0] eoc_current_code;
    logic [2:0] vterm_warm_code;
    logic [2:0] vterm_hot_code;
  } cscr_cfg_warm_type;

  // Battery temperature band reported by the thermistor comparators.
  typedef enum logic [2:0] {
    BAND_COLD  = 3'h0,
    BAND_0_10  = 3'h1,
    BAND_10_45 = 3'h2,
    BAND_45_50 = 3'h3,
    BAND_50_60 = 3'h4,
    BAND_HOT   = 3'h5
  } cscr_band_type;

  // Event levels from the analog supervisors.
  typedef struct packed {
    logic overvoltage;
    logic full_charge_timeout;
    logic thermal_shutdown;
    logic topoff_timeout;
    logic input_undervoltage;
    logic thermistor_open;
  } cscr_event_type;

  // Charger settings handed to the analog loop.
  typedef struct packed {
    logic [1:0] precharge_current_code;
    logic [1:0] eoc_current_code;
    logic [2:0] vterm_code;
    logic       vterm_valid;
    logic       charge_enable;
  } cscr_setting_type;

endpackage
`default_nettype wire

// *** rtl/cscr_sync3.sv ***
/*
  Three-stage input synchroniser with agreement filter, one lane per bit.
  Assumes the inputs come from outside the clock domain; the output only
  changes once the second and third stages agree.
*/
`default_nettype none
module cscr_sync3 #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  genvar g;

  // Each lane is independent; multi-bit codes may settle over a few cycles.
  generate
    for (g = 0; g < W; g++)
    begin : g_lane
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic q_r;

      // The first stage feeds only the second stage.
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          s1_r <= RST_VAL[g];
          s2_r <= RST_VAL[g];
          s3_r <= RST_VAL[g];
          q_r  <= RST_VAL[g];
        end
        else if (i_ce)
        begin
          s1_r <= i_d[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
          begin
            q_r <= s3_r;
          end
        end
      end

      assign o_q[g] = q_r;
    end
  endgenerate

endmodule
`default_nettype wire

// *** rtl/cscr_top.sv ***
/*
  Charger status and configuration register bank with its serial slave.
  Holds the sticky status byte, the two termination/current configuration
  bytes, the configuration-enable byte and the active-low fault output.
  Assumes a two-wire serial master on the clock/data pins, external pull-ups,
  and analog supervisors that present level events and a temperature band.
*/
`default_nettype none
module cscr_top (
  input  wire logic                     I_CLK_SYS,
  input  wire logic                     I_RESETN,
  input  wire logic                     I_CE,
  input  wire logic                     I_SCL,
  input  wire logic                     I_SDA,
  output logic                          O_SDA,
  output logic                          O_SDA_OE,
  input  wire logic                     I_FAULT_ALERT_LOW,
  output logic                          O_FAULT_ALERT_LOW,
  output logic                          O_FAULT_ALERT_LOW_OE,
  input  wire cscr_pkg::cscr_event_type I_EVENTS,
  input  wire cscr_pkg::cscr_band_type  I_TEMP_BAND,
  output cscr_pkg::cscr_setting_type    O_SETTING
);
  import cscr_pkg::*;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } cscr_state_type;

  logic              rst_a_r;
  logic              rst_n;
  logic              scl;
  logic              sda;
  logic              scl_d_r;
  logic              sda_d_r;
  cscr_event_type    evt;
  cscr_band_type     band;
  logic [2:0]        band_raw;
  cscr_state_type    state_r;
  logic [7:0]        sh_r;
  logic [3:0]        cnt_r;
  logic [7:0]        ptr_r;
  logic              rw_r;
  logic              sda_oe_r;
  cscr_status_type   status_r;
  cscr_status_type   status_set;
  logic              status_clr;
  cscr_cfg_cool_type cfg_cool_r;
  cscr_cfg_warm_type cfg_warm_r;
  logic [7:0]        cfg_en_r;
  logic              cfg_open;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;
  logic              wr_strobe;
  logic              load_rd;
  logic [7:0]        rd_byte;
  cscr_setting_type  setting_r;

  // Configuration bytes are gated by the enable bit for both reads and writes.
  function automatic logic is_cfg(input logic [7:0] a);
    is_cfg = (a == OFS_CFG_COOL) || (a == OFS_CFG_WARM);
  endfunction

  // Reset release through two flip-flops; assertion stays asynchronous.
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      rst_a_r <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      rst_a_r <= 1'b1;
      rst_n   <= rst_a_r;
    end
  end

  // The bus pins and the analog inputs cross into the clock domain here.
  cscr_sync3 #(
    .W       (11),
    .RST_VAL (11'h600)
  ) u_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_n),
    .i_ce    (I_CE),
    .i_d     ({I_SCL, I_SDA, I_EVENTS, I_TEMP_BAND}),
    .o_q     ({scl, sda, evt, band_raw})
  );

  assign band = cscr_band_type'(band_raw);

  // Delayed copies of the filtered lines for edge and bus-condition detection.
  always_ff @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else if (I_CE)
    begin
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  assign scl_rise   = scl & ~scl_d_r;
  assign scl_fall   = ~scl & scl_d_r;
  assign start_cond = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_cond  = scl & scl_d_r & ~sda_d_r & sda;
  assign cfg_open   = cfg_en_r[CFG_EN_BIT];

  // A byte is written when its last data bit has been taken in write state.
  assign wr_strobe = scl_fall && (state_r == ST_WDATA) && (cnt_r == BITS_PER_BYTE);
  // A byte is fetched for transmit after the address ack or a master ack.
  assign load_rd   = scl_fall && (((state_r == ST_ADDR_ACK) && rw_r) || (state_r == ST_RDATA_ACK));

  // Byte at the pointer; a process keeps it sensitive to the registers read inside the function.
  always_comb
  begin
    rd_byte = read_byte(ptr_r);
  end

  // Serial slave sequencer: address, register pointer, then data bytes.
  always_ff @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r  <= ST_IDLE;
      sh_r     <= READ_ZERO;
      cnt_r    <= BIT_CNT_ZERO;
      ptr_r    <= OFS_STATUS;
      rw_r     <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (I_CE)
    begin
      if (start_cond)
      begin
        state_r  <= ST_ADDR;
        cnt_r    <= BIT_CNT_ZERO;
        sda_oe_r <= 1'b0;
      end
      else if (stop_cond)
      begin
        state_r  <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end
      else if (scl_rise)
      begin
        unique case (state_r)
          ST_ADDR, ST_REG, ST_WDATA:
          begin
            sh_r  <= {sh_r[6:0], sda};
            cnt_r <= cnt_r + BIT_CNT_ONE;
          end
          ST_RDATA:
          begin
            cnt_r <= cnt_r + BIT_CNT_ONE;
          end
          ST_RDATA_ACK:
          begin
            // A not-acknowledge ends the read burst.
            if (sda)
            begin
              state_r <= ST_IDLE;
            end
          end
          ST_IDLE, ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK:
          begin
          end
        endcase
      end
      else if (scl_fall)
      begin
        unique case (state_r)
          ST_ADDR:
          begin
            if (cnt_r == BITS_PER_BYTE)
            begin
              if (sh_r[7:1] == SLAVE_ADDR)
              begin
                rw_r     <= sh_r[0];
                sda_oe_r <= 1'b1;
                state_r  <= ST_ADDR_ACK;
              end
              else
              begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_REG:
          begin
            if (cnt_r == BITS_PER_BYTE)
            begin
              ptr_r    <= sh_r;
              sda_oe_r <= 1'b1;
              state_r  <= ST_REG_ACK;
            end
          end
          ST_WDATA:
          begin
            if (cnt_r == BITS_PER_BYTE)
            begin
              ptr_r    <= ptr_r + PTR_STEP;
              sda_oe_r <= 1'b1;
              state_r  <= ST_WDATA_ACK;
            end
          end
          ST_ADDR_ACK, ST_RDATA_ACK:
          begin
            cnt_r <= BIT_CNT_ZERO;
            if (load_rd)
            begin
              sh_r     <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
              ptr_r    <= ptr_r + PTR_STEP;
              state_r  <= ST_RDATA;
            end
            else
            begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_REG;
            end
          end
          ST_REG_ACK, ST_WDATA_ACK:
          begin
            cnt_r    <= BIT_CNT_ZERO;
            sda_oe_r <= 1'b0;
            state_r  <= ST_WDATA;
          end
          ST_RDATA:
          begin
            if (cnt_r == BITS_PER_BYTE)
            begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_RDATA_ACK;
            end
            else
            begin
              sh_r     <= {sh_r[6:0], 1'b0};
              sda_oe_r <= ~sh_r[6];
            end
          end
          ST_IDLE:
          begin
          end
        endcase
      end
    end
  end

  // Read multiplexer; closed configuration bytes and unmapped offsets read zero.
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    if (a == OFS_STATUS)
    begin
      read_byte = status_r;
    end
    else if (is_cfg(a) && !cfg_open)
    begin
      read_byte = READ_ZERO;
    end
    else if (a == OFS_CFG_COOL)
    begin
      read_byte = cfg_cool_r;
    end
    else if (a == OFS_CFG_WARM)
    begin
      read_byte = cfg_warm_r;
    end
    else if (a == OFS_CFG_ENABLE)
    begin
      read_byte = cfg_en_r;
    end
    else
    begin
      read_byte = READ_ZERO;
    end
  endfunction

  // Event sources: two come from the temperature band, the rest from supervisors.
  always_comb
  begin
    status_set                          = STATUS_RST;
    status_set.battery_overvoltage_flag = evt.overvoltage;
    status_set.full_charge_timeout_flag = evt.full_charge_timeout;
    status_set.too_cold_flag            = (band == BAND_COLD);
    status_set.too_hot_flag             = (band == BAND_HOT);
    status_set.thermal_shutdown_flag    = evt.thermal_shutdown;
    status_set.topoff_timeout_flag      = evt.topoff_timeout;
    status_set.input_undervoltage_flag  = evt.input_undervoltage;
    status_set.thermistor_open_flag     = evt.thermistor_open;
  end

  // The status byte is cleared when it is fetched for transmit.
  assign status_clr = load_rd && (ptr_r == OFS_STATUS);

  // Sticky status; a present event wins over the clearing read.
  always_ff @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_r <= STATUS_RST;
    end
    else if (I_CE)
    begin
      status_r <= (status_clr ? STATUS_RST : status_r) | status_set;
    end
  end

  // Host writes; the status offset has no write path at all.
  always_ff @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_cool_r <= CFG_COOL_RST;
      cfg_warm_r <= CFG_WARM_RST;
      cfg_en_r   <= CFG_ENABLE_RST;
    end
    else if (I_CE && wr_strobe)
    begin
      if (ptr_r == OFS_CFG_ENABLE)
      begin
        cfg_en_r <= sh_r;
      end
      else if (is_cfg(ptr_r) && cfg_open)
      begin
        if (ptr_r == OFS_CFG_COOL)
        begin
          cfg_cool_r <= sh_r;
        end
        else
        begin
          cfg_warm_r <= sh_r;
        end
      end
    end
  end

  // Settings for the analog loop; the termination code is picked by the present temperature band.
  always_ff @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setting_r <= '0;
    end
    else if (I_CE)
    begin
      setting_r.precharge_current_code <= cfg_cool_r.precharge_current_code;
      setting_r.eoc_current_code       <= cfg_warm_r.eoc_current_code;
      unique case (band)
        BAND_0_10:  setting_r.vterm_code <= cfg_cool_r.vterm_cool_code;
        BAND_10_45: setting_r.vterm_code <= cfg_cool_r.vterm_mild_code;
        BAND_45_50: setting_r.vterm_code <= cfg_warm_r.vterm_warm_code;
        BAND_50_60: setting_r.vterm_code <= cfg_warm_r.vterm_hot_code;
        default:    setting_r.vterm_code <= VTERM_INVALID;
      endcase
      // Code 7 is marked valid for one cycle at most; valid and charging drop the cycle after it appears.
      setting_r.vterm_valid   <= (setting_r.vterm_code != VTERM_INVALID);
      setting_r.charge_enable <= (setting_r.vterm_code != VTERM_INVALID) && !evt.overvoltage &&
                                 !evt.full_charge_timeout && (band != BAND_COLD) && (band != BAND_HOT);
    end
  end

  assign O_SETTING = setting_r;

  // Open-drain pins: the low level is always presented, the enable does the work.
  assign O_SDA                = 1'b0;
  assign O_SDA_OE             = sda_oe_r;
  assign O_FAULT_ALERT_LOW    = 1'b0;
  // Only the fault nibble drives the pin, so it releases once a read clears it.
  assign O_FAULT_ALERT_LOW_OE = |(status_r & FAULT_MASK);

endmodule
`default_nettype wire

// *** test/cscr_chk.sv ***
/*
  Port-level checker for the charger status and configuration bank.
  Assumes it is bound to cscr_top and that the bus phases last ten cycles.
*/
`default_nettype none
module cscr_chk
  import cscr_pkg::*;
(
  input wire logic             I_CLK_SYS,
  input wire logic             I_RESETN,
  input wire logic             I_CE,
  input wire logic             I_SCL,
  input wire logic             I_SDA,
  input wire logic             O_SDA,
  input wire logic             O_SDA_OE,
  input wire logic             I_FAULT_ALERT_LOW,
  input wire logic             O_FAULT_ALERT_LOW,
  input wire logic             O_FAULT_ALERT_LOW_OE,
  input wire cscr_event_type   I_EVENTS,
  input wire cscr_band_type    I_TEMP_BAND,
  input wire cscr_setting_type O_SETTING
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       cause;
  logic       scl_d_r;
  logic [3:0] fault_age_r;
  logic [3:0] fall_age_r;

  // A fault cause is any input that should end in a fault bit.
  assign cause = I_EVENTS.overvoltage | I_EVENTS.full_charge_timeout |
                 (I_TEMP_BAND == BAND_COLD) | (I_TEMP_BAND == BAND_HOT);

  // Reset counts as a cause, since the band synchroniser starts at the cold code.
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
    if (!I_RESETN) fault_age_r <= 4'h0;
    else if (cause) fault_age_r <= 4'h0;
    else if (fault_age_r != 4'hF) fault_age_r <= fault_age_r + 4'h1;

  // Ages saturate so that they never wrap back into a window.
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
    if (!I_RESETN) scl_d_r <= 1'b1;
    else scl_d_r <= I_SCL;
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
    if (!I_RESETN) fall_age_r <= 4'hF;
    else if (scl_d_r && !I_SCL) fall_age_r <= 4'h0;
    else if (fall_age_r != 4'hF) fall_age_r <= fall_age_r + 4'h1;

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESETN || !I_CE);

  sequence fault_held;
    cause [*4];
  endsequence

  a_sda_low_value: assert property (O_SDA == 1'b0)
    else $error("SDA output value is not low");
  a_alert_low_value: assert property (O_FAULT_ALERT_LOW == 1'b0)
    else $error("Alert output value is not low");
  a_fault_alert: assert property (fault_held |-> ##[1:10] O_FAULT_ALERT_LOW_OE)
    else $error("Fault did not pull the alert low");
  a_warn_no_alert: assert property ($rose(O_FAULT_ALERT_LOW_OE) |-> fault_age_r < 4'hC)
    else $error("Alert pulled low without a fault");
  a_alert_release: assert property ($fell(O_FAULT_ALERT_LOW_OE) |-> fall_age_r <= 4'hA)
    else $error("Alert released outside a status fetch");
  a_sda_stable_high: assert property ($changed(O_SDA_OE) |-> !I_SCL)
    else $error("SDA drive changed while SCL high");
  a_charge_block: assert property (fault_held |-> ##[0:8] !O_SETTING.charge_enable)
    else $error("Charging not stopped on a fault");
  a_vterm_invalid: assert property (O_SETTING.vterm_code == VTERM_INVALID |=> !O_SETTING.vterm_valid)
    else $error("Invalid termination code marked valid");
endmodule
`default_nettype wire

// *** test/cscr_host.sv ***
/*
  Two-wire bus master model that stands in for the host controller.
  Assumes SDA is resolved outside with a pull-up and that SCL is not stretched.
*/
`default_nettype none
module cscr_host
  import cscr_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PHASE = 10;

  // The bus idles released; phases stay well above the six-cycle minimum.
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic wt();
    repeat (PHASE) @(posedge i_clk);
    #1;
  endtask

  task automatic start();
    o_sda_low = 1'b0;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_low = 1'b1;
    wt();
    o_scl = 1'b0;
  endtask

  task automatic stop();
    o_sda_low = 1'b1;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_low = 1'b0;
    wt();
  endtask

  // Nine bits, MSB first; data is set while SCL is low and sampled at the end of high.
  task automatic xbyte(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      o_sda_low = !w[i];
      wt();
      o_scl = 1'b1;
      wt();
      r[i] = i_sda;
      o_scl = 1'b0;
    end
  endtask

  // Pointer then up to two data bytes; ack is true only if every byte was acknowledged.
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] d,
                    input int n, output logic ack);
    logic [8:0] r;
    start();
    xbyte({dev, 2'b01}, r);
    ack = !r[0];
    xbyte({ptr, 1'b1}, r);
    ack &= !r[0];
    for (int k = 0; k < n; k++)
    begin
      xbyte({d[15-8*k -: 8], 1'b1}, r);
      ack &= !r[0];
    end
    stop();
  endtask

  // Sets the pointer, then reads n bytes; the last one is refused to end the read.
  task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] q);
    logic [8:0] r;
    logic       a;
    q = '0;
    wr(SLAVE_ADDR, ptr, 16'h0000, 0, a);
    start();
    xbyte({SLAVE_ADDR, 2'b11}, r);
    for (int k = 0; k < n; k++)
    begin
      xbyte({8'hFF, 1'(k == n - 1)}, r);
      q = {q[7:0], r[8:1]};
    end
    stop();
  endtask
endmodule
`default_nettype wire

// *** test/tb_charger_status_config_regs.sv ***
/*
  Self-checking bench for the charger status and configuration bank.
  Assumes cscr_host drives the bus and cscr_chk is bound to the top level.
*/
`default_nettype none
module tb_charger_status_config_regs;
  import cscr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic             clk;
  logic             rst_n;
  logic             ce;
  logic             scl;
  logic             sda_low;
  logic             sda_oe;
  logic             alert_oe;
  logic             a;
  logic [15:0]      q;
  logic [15:0]      c;
  logic [31:0]      seed;
  logic [5:0]       m;
  cscr_event_type   ev;
  cscr_band_type    band;
  cscr_setting_type set;
  wire logic        sda;
  int               err_count;
  int               num_checks;

  // Open-drain data line with its pull-up.
  assign sda = !(sda_low | sda_oe);

  cscr_top i_cscr_top (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_CE(ce), .I_SCL(scl), .I_SDA(sda),
    .O_SDA(), .O_SDA_OE(sda_oe), .I_FAULT_ALERT_LOW(!alert_oe), .O_FAULT_ALERT_LOW(),
    .O_FAULT_ALERT_LOW_OE(alert_oe), .I_EVENTS(ev), .I_TEMP_BAND(band), .O_SETTING(set));
  cscr_host i_cscr_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  always #10 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Termination code that the given band should take from the two config bytes.
  function automatic logic [2:0] exp_vterm(input int b, input logic [15:0] v);
    case (b)
      1: return v[13:11];
      2: return v[10:8];
      3: return v[5:3];
      default: return v[2:0];
    endcase
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch.
  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    ev = '0;
    band = BAND_10_45;
    seed = 32'h7A9E;
    err_count = 0;
    num_checks = 0;
    wt(5);
    chk("setting in reset", 16'h0000, 16'(set));
    rst_n = 1'b1;
    wt(10);
    // The synchroniser starts at the cold code, so the first fetch only clears that flag.
    i_cscr_host.rd(OFS_STATUS, 1, q);
    chk("alert after clear", 16'h0000, 16'(alert_oe));
    i_cscr_host.wr(7'h49, OFS_CFG_COOL, 16'h0000, 0, a);
    chk("foreign address ack", 16'h0000, 16'(a));
    i_cscr_host.wr(SLAVE_ADDR, OFS_CFG_COOL, 16'hA5A5, 2, a);
    chk("own address ack", 16'h0001, 16'(a));
    i_cscr_host.rd(OFS_CFG_COOL, 2, q);
    chk("locked config", 16'h0000, q);
    i_cscr_host.wr(SLAVE_ADDR, OFS_CFG_ENABLE, 16'h0100, 1, a);
    i_cscr_host.rd(OFS_CFG_COOL, 2, q);
    chk("config reset", {CFG_COOL_RST, CFG_WARM_RST}, q);
    // All-ones first so the invalid code reaches each of the four bands that take a code from the config bytes.
    for (int n = 0; n < 5; n++)
    begin
      seed = xs(seed);
      c = (n == 0) ? 16'hFFFF : seed[15:0];
      i_cscr_host.wr(SLAVE_ADDR, OFS_CFG_COOL, c, 2, a);
      i_cscr_host.rd(OFS_CFG_COOL, 2, q);
      chk("config readback", c, q);
      for (int b = 1; b < 5; b++)
      begin
        band = cscr_band_type'(b);
        wt(12);
        chk("vterm code", 16'(exp_vterm(b, c)), 16'(set.vterm_code));
        chk("current codes", {12'h000, c[15:14], c[7:6]},
            16'({set.precharge_current_code, set.eoc_current_code}));
        chk("vterm valid", 16'(exp_vterm(b, c) != 3'h7), 16'(set.vterm_valid));
      end
    end
    band = BAND_10_45;
    wt(12);
    // One cause at a time: bits 7 and 6 and 3 to 0 from events, 5 and 4 from the band.
    for (int k = 0; k < 8; k++)
    begin
      m = (k >= 6) ? 6'(1 << (k - 2)) : ((k < 4) ? 6'(1 << k) : 6'h00);
      ev = cscr_event_type'(m);
      band = (k == 5) ? BAND_COLD : ((k == 4) ? BAND_HOT : BAND_10_45);
      wt(12);
      chk("alert on event", 16'(k >= 4), 16'(alert_oe));
      if (k == 4 || k == 5 || k >= 6)
        chk("charging stopped", 16'h0000, 16'(set.charge_enable));
      ev = '0;
      band = BAND_10_45;
      wt(12);
      chk("alert held", 16'(k >= 4), 16'(alert_oe));
      i_cscr_host.rd(OFS_STATUS, 1, q);
      chk("status bit", 16'(8'h01 << k), q);
      i_cscr_host.rd(OFS_STATUS, 1, q);
      chk("status cleared", 16'h0000, q);
      chk("alert released", 16'h0000, 16'(alert_oe));
    end
    // A low clock enable freezes the input stages, so a new fault stays unseen until it rises.
    ce = 1'b0;
    ev = cscr_event_type'(6'h20);
    wt(12);
    chk("alert frozen", 16'h0000, 16'(alert_oe));
    ce = 1'b1;
    wt(12);
    chk("alert after enable", 16'h0001, 16'(alert_oe));
    ev = '0;
    wt(12);
    i_cscr_host.rd(OFS_STATUS, 1, q);
    chk("status after enable", 16'h0080, q);
    // A held warning survives both a host write and clearing fetches.
    ev = cscr_event_type'(6'h08);
    wt(12);
    seed = xs(seed);
    i_cscr_host.wr(SLAVE_ADDR, OFS_STATUS, {seed[7:0], 8'h00}, 1, a);
    i_cscr_host.rd(OFS_STATUS, 1, q);
    chk("status after write", 16'h0008, q);
    i_cscr_host.rd(OFS_STATUS, 1, q);
    chk("status re-set", 16'h0008, q);
    ev = '0;
    wt(12);
    i_cscr_host.rd(OFS_STATUS, 1, q);
    chk("status sticky", 16'h0008, q);
    i_cscr_host.rd(OFS_STATUS, 1, q);
    chk("status final", 16'h0000, q);
    summarize();
  end
endmodule

bind cscr_top cscr_chk i_cscr_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_CE(I_CE),
  .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .I_FAULT_ALERT_LOW(I_FAULT_ALERT_LOW),
  .O_FAULT_ALERT_LOW(O_FAULT_ALERT_LOW), .O_FAULT_ALERT_LOW_OE(O_FAULT_ALERT_LOW_OE),
  .I_EVENTS(I_EVENTS), .I_TEMP_BAND(I_TEMP_BAND), .O_SETTING(O_SETTING));
`default_nettype wire
